// ==== hdl/sdi_rx.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdi_rx
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // link from the serial source
  sdi_link_if.dev link,
  // configuration
  input wire sdi_pkg::sdi_fmt_e fmt_i,
  input wire sdi_pkg::sdi_width_e width_i,
  input wire logic osr384_i,
  input wire logic oversampling_clock_i,
  // sample pair to the encoder
  output logic pair_valid_o,
  input wire logic pair_ready_i,
  output logic [23:0] left_o,
  output logic [23:0] right_o,
  // biphase clock
  output logic biphase_clk_o
);
  import sdi_pkg::*;

  // pin synchronisers, two stages each
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] next_sync1;
  logic [3:0] next_sync2;
  logic bclk_d;
  logic next_bclk_d;
  logic rise;
  logic osc_d;
  logic next_osc_d;
  logic osc_rise;

  always_comb
  begin
    next_sync1 = {oversampling_clock_i, link.serial_input_data, link.lrclk, link.bclk};
    next_sync2 = sync1;
    next_bclk_d = sync2[0];
    next_osc_d = sync2[3];
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      bclk_d <= 1'b0;
      osc_d <= 1'b0;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      bclk_d <= next_bclk_d;
      osc_d <= next_osc_d;
    end
  end

  // sampling on the rising bit clock edge only
  assign rise = sync2[0] & ~bclk_d; // RULE3
  assign osc_rise = sync2[3] & ~osc_d;

  // capture state
  logic lr_prev;
  logic [5:0] bitcnt;
  logic [SDI_MAXW-1:0] shreg;
  logic [SDI_MAXW-1:0] lhold;
  logic got_left;
  logic [5:0] wbits;
  logic [5:0] start;
  logic left_now;
  logic next_lr_prev;
  logic [5:0] next_bitcnt;
  logic [SDI_MAXW-1:0] next_shreg;
  logic [SDI_MAXW-1:0] next_lhold;
  logic next_got_left;
  logic push;
  logic [SDI_MAXW-1:0] push_l;
  logic [SDI_MAXW-1:0] push_r;
  logic word_done;
  logic [SDI_MAXW-1:0] word;

  always_comb
  begin
    unique case (width_i) // RULE2
      SDI_W16: wbits = SDI_W16_BITS;
      SDI_W18: wbits = SDI_W18_BITS;
      SDI_W20: wbits = SDI_W20_BITS;
      SDI_W24: wbits = SDI_W24_BITS;
    endcase
    // first sampled bit index within the channel slot
    unique case (fmt_i) // RULE1
      SDI_FMT_LJ: start = 6'h00; // RULE9
      SDI_FMT_I2S: start = 6'h01; // RULE8
      // right-justified: LSB lands in the last slot period
      SDI_FMT_RJ: start = 6'(SDI_SLOT) - wbits; // RULE5 RULE6
      default: start = 6'h01;
    endcase
    // channel polarity; I2S is the only one with low meaning left
    left_now = (fmt_i == SDI_FMT_I2S) ? ~sync2[1] : sync2[1]; // RULE4 RULE7 RULE9
  end

  always_comb
  begin
    next_lr_prev = lr_prev;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_lhold = lhold;
    next_got_left = got_left;
    word_done = 1'b0;
    word = shreg;
    push = 1'b0;
    push_l = lhold;
    push_r = shreg;
    if (rise)
    begin
      next_lr_prev = sync2[1];
      if (sync2[1] != lr_prev)
        next_bitcnt = 6'h00;
      else if (bitcnt != 6'h3f)
        next_bitcnt = bitcnt + 6'h01;
      // the bit at this edge belongs to slot position next_bitcnt
      if (next_bitcnt >= start && next_bitcnt < start + wbits)
      begin
        next_shreg = {shreg[SDI_MAXW-2:0], sync2[2]}; // RULE12
        if (next_bitcnt == start + wbits - 6'h01)
        begin
          word_done = 1'b1;
          // left justify into 24 bits so widths share one layout
          word = next_shreg << (6'(SDI_MAXW) - wbits);
          if (left_now)
          begin
            next_lhold = word;
            next_got_left = 1'b1;
          end
          else if (got_left)
          begin
            push = 1'b1; // RULE12
            push_r = word;
            next_got_left = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lr_prev <= 1'b0;
      bitcnt <= 6'h3f;
      shreg <= '0;
      lhold <= '0;
      got_left <= 1'b0;
    end
    else
    begin
      lr_prev <= next_lr_prev;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      lhold <= next_lhold;
      got_left <= next_got_left;
    end
  end

  // two-entry pair buffer; a full buffer drops the pair rather than stall the pins
  logic [2*SDI_MAXW-1:0] buf_q [2];
  logic [1:0] buf_v;
  logic wptr;
  logic rptr;
  logic [2*SDI_MAXW-1:0] next_buf0;
  logic [2*SDI_MAXW-1:0] next_buf1;
  logic [1:0] next_buf_v;
  logic next_wptr;
  logic next_rptr;
  logic next_pair_valid;
  logic [23:0] next_left;
  logic [23:0] next_right;
  logic do_push;
  logic do_pop;

  always_comb
  begin
    next_buf0 = buf_q[0];
    next_buf1 = buf_q[1];
    next_buf_v = buf_v;
    next_wptr = wptr;
    next_rptr = rptr;
    next_pair_valid = pair_valid_o;
    next_left = left_o;
    next_right = right_o;
    do_pop = pair_valid_o && pair_ready_i;
    do_push = push && !buf_v[wptr];
    if (do_pop)
      next_pair_valid = 1'b0;
    if (do_push)
    begin
      if (wptr)
        next_buf1 = {push_l, push_r};
      else
        next_buf0 = {push_l, push_r};
      next_buf_v[wptr] = 1'b1;
      next_wptr = ~wptr;
    end
    // output stage reloads from the buffer head when empty or draining
    if ((!pair_valid_o || do_pop) && buf_v[rptr])
    begin
      next_pair_valid = 1'b1;
      {next_left, next_right} = rptr ? buf_q[1] : buf_q[0];
      next_buf_v[rptr] = 1'b0;
      next_rptr = ~rptr;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      buf_v <= 2'h0;
      wptr <= 1'b0;
      rptr <= 1'b0;
      pair_valid_o <= 1'b0;
      left_o <= 24'h000000;
      right_o <= 24'h000000;
    end
    else
    begin
      buf_q[0] <= next_buf0;
      buf_q[1] <= next_buf1;
      buf_v <= next_buf_v;
      wptr <= next_wptr;
      rptr <= next_rptr;
      pair_valid_o <= next_pair_valid;
      left_o <= next_left;
      right_o <= next_right;
    end
  end

  // biphase clock: 64 per frame, toggled every div rising oversampling edges
  logic [8:0] oscnt;
  logic [8:0] next_oscnt;
  logic next_biphase;
  logic [8:0] div;

  always_comb
  begin
    div = osr384_i ? SDI_OSR384_DIV : SDI_OSR256_DIV; // RULE11
    next_oscnt = oscnt;
    next_biphase = biphase_clk_o;
    if (osc_rise)
    begin
      if (oscnt + 9'h001 >= div)
      begin
        next_oscnt = 9'h000;
        next_biphase = ~biphase_clk_o; // RULE10
      end
      else
        next_oscnt = oscnt + 9'h001;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      oscnt <= 9'h000;
      biphase_clk_o <= 1'b0;
    end
    else
    begin
      oscnt <= next_oscnt;
      biphase_clk_o <= next_biphase;
    end
  end
endmodule // sdi_rx
`default_nettype wire

// ==== hdl/sdi_pkg.sv ====
// Summary of operation
// RULE1: three framings: left, I2S, right justified
// RULE2: word widths 16, 18, 20, 24 bits
// RULE3: data and channel clock sampled rising edge
// RULE4: right-justified: high channel clock is left
// RULE5: right-justified MSB delayed 12 or 16 periods; code delays 32 minus word width, 8 to 16
// RULE6: right-justified LSB ends before next transition
// RULE7: I2S default; low channel clock is left
// RULE8: I2S MSB one bit period after transition
// RULE9: left-justified: high is left, no delay
// RULE10: biphase clock divided from oversampling clock
// RULE11: oversampling 256 or 384 times frame rate
// RULE12: MSB first; completed pairs registered before encoder
`default_nettype none
package sdi_pkg;
  typedef enum logic [1:0] {
    SDI_FMT_LJ = 2'h0,
    SDI_FMT_I2S = 2'h1,
    SDI_FMT_RJ = 2'h2
  } sdi_fmt_e;
  typedef enum logic [1:0] {
    SDI_W16 = 2'h0,
    SDI_W18 = 2'h1,
    SDI_W20 = 2'h2,
    SDI_W24 = 2'h3
  } sdi_width_e;
  localparam int SDI_MAXW = 24;
  localparam int SDI_SLOT = 32;
  localparam logic [4:0] SDI_SLOT_LAST = 5'h1f;
  localparam logic [5:0] SDI_W16_BITS = 6'h10;
  localparam logic [5:0] SDI_W18_BITS = 6'h12;
  localparam logic [5:0] SDI_W20_BITS = 6'h14;
  localparam logic [5:0] SDI_W24_BITS = 6'h18;
  // bit clock half period in system clocks; the 80 ns pin minimum alone would push
  // 64 bit clocks per frame above the top frame rate, so the slower of the two wins
  localparam int SDI_CLK_NS = 4;
  localparam int SDI_BCLK_MIN_NS = 80;
  localparam int SDI_FS_MAX_HZ = 192000;
  localparam int SDI_BCLK_PER_FRAME = 64;
  localparam int SDI_FRAME_MIN_NS = (1000000000 + SDI_FS_MAX_HZ - 1) / SDI_FS_MAX_HZ;
  localparam int SDI_BCLK_FS_NS =
    (SDI_FRAME_MIN_NS + SDI_BCLK_PER_FRAME - 1) / SDI_BCLK_PER_FRAME;
  localparam int SDI_BCLK_NS =
    (SDI_BCLK_FS_NS > SDI_BCLK_MIN_NS) ? SDI_BCLK_FS_NS : SDI_BCLK_MIN_NS;
  localparam int SDI_BCLK_HALF = (SDI_BCLK_NS / 2 + SDI_CLK_NS - 1) / SDI_CLK_NS;
  localparam logic [4:0] SDI_BCLK_HALF_LAST = 5'(SDI_BCLK_HALF - 1);
  // dividers for oversampling 256 or 384 per frame; biphase clock is 64 per frame
  localparam logic [8:0] SDI_OSR256_DIV = 9'h002;
  localparam logic [8:0] SDI_OSR384_DIV = 9'h003;
endpackage
`default_nettype wire

// ==== hdl/sdi_link_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface sdi_link_if;
  logic bclk;
  logic lrclk;
  logic serial_input_data;
  modport src (output bclk, output lrclk, output serial_input_data);
  modport dev (input bclk, input lrclk, input serial_input_data);
endinterface
`default_nettype wire

// ==== hdl/sdi_src.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdi_src
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // configuration
  input wire sdi_pkg::sdi_fmt_e fmt_i,
  input wire sdi_pkg::sdi_width_e width_i,
  // sample pair from user
  input wire logic pair_valid_i,
  output logic pair_ready_o,
  input wire logic [23:0] left_i,
  input wire logic [23:0] right_i,
  // link to the device
  sdi_link_if.src link
);
  import sdi_pkg::*;

  logic [4:0] hcnt;
  logic bclk;
  logic lr;
  logic [4:0] slot;
  logic sd;
  logic [23:0] l_q;
  logic [23:0] r_q;
  logic rdy;
  logic [4:0] next_hcnt;
  logic next_bclk;
  logic next_lr;
  logic [4:0] next_slot;
  logic next_sd;
  logic [23:0] next_l;
  logic [23:0] next_r;
  logic next_rdy;
  logic [5:0] wbits;
  logic [5:0] start;
  logic [5:0] pos;
  logic left_ch;
  logic [23:0] cur;

  assign link.bclk = bclk;
  assign link.lrclk = lr;
  assign link.serial_input_data = sd;
  assign pair_ready_o = rdy;

  always_comb
  begin
    unique case (width_i)
      SDI_W16: wbits = SDI_W16_BITS;
      SDI_W18: wbits = SDI_W18_BITS;
      SDI_W20: wbits = SDI_W20_BITS;
      SDI_W24: wbits = SDI_W24_BITS;
    endcase
    unique case (fmt_i)
      SDI_FMT_LJ: start = 6'h00; // RULE9
      SDI_FMT_I2S: start = 6'h01; // RULE8
      SDI_FMT_RJ: start = 6'(SDI_SLOT) - wbits; // RULE5 RULE6
      default: start = 6'h01;
    endcase
    next_hcnt = hcnt + 5'h01;
    next_bclk = bclk;
    next_lr = lr;
    next_slot = slot;
    next_sd = sd;
    next_l = l_q;
    next_r = r_q;
    next_rdy = 1'b0;
    pos = 6'h00;
    left_ch = 1'b0;
    cur = 24'h000000;
    if (hcnt == SDI_BCLK_HALF_LAST)
    begin
      next_hcnt = 5'h00;
      next_bclk = ~bclk;
      // change data and channel clock on the falling edge only
      if (bclk) // RULE3
      begin
        next_slot = slot + 5'h01;
        if (slot == SDI_SLOT_LAST)
        begin
          next_lr = ~lr;
          // a new frame starts on the left: take the next pair
          if ((fmt_i == SDI_FMT_I2S) == lr) // RULE7 RULE4
          begin
            next_rdy = 1'b1;
            next_l = pair_valid_i ? left_i : 24'h000000;
            next_r = pair_valid_i ? right_i : 24'h000000;
          end
        end
        left_ch = (fmt_i == SDI_FMT_I2S) ? ~next_lr : next_lr;
        cur = left_ch ? next_l : next_r;
        pos = {1'b0, next_slot} - start;
        if ({1'b0, next_slot} >= start && pos < wbits)
          next_sd = cur[5'(6'(SDI_MAXW - 1) - pos)]; // RULE12
        else
          next_sd = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hcnt <= 5'h00;
      bclk <= 1'b0;
      lr <= 1'b1;
      slot <= SDI_SLOT_LAST;
      sd <= 1'b0;
      l_q <= 24'h000000;
      r_q <= 24'h000000;
      rdy <= 1'b0;
    end
    else
    begin
      hcnt <= next_hcnt;
      bclk <= next_bclk;
      lr <= next_lr;
      slot <= next_slot;
      sd <= next_sd;
      l_q <= next_l;
      r_q <= next_r;
      rdy <= next_rdy;
    end
  end
endmodule // sdi_src
`default_nettype wire

// ==== bench/sdi_link_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdi_link_properties
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // link signals
  input wire logic bclk,
  input wire logic lrclk,
  input wire logic serial_input_data
);
  logic lr_q, bclk_q, seen, next_seen, chg;
  logic [9:0] ncyc, next_ncyc;
  logic [5:0] nbit, next_nbit;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  assign chg = lrclk != lr_q;
  // the first half after reset may be short, so lengths count from the second change on
  always_comb
  begin
    next_seen = seen | chg;
    next_ncyc = chg ? 10'h000 : ncyc + 10'h001;
    next_nbit = chg ? 6'h00 : nbit + {5'h00, bclk & !bclk_q};
  end
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lr_q <= 1'b1;
      bclk_q <= 1'b0;
      seen <= 1'b0;
      ncyc <= 10'h000;
      nbit <= 6'h00;
    end
    else
    begin
      lr_q <= lrclk;
      bclk_q <= bclk;
      seen <= next_seen;
      ncyc <= next_ncyc;
      nbit <= next_nbit;
    end
  end
  a_bclk_high: assert property ($rose(bclk) |-> ##11 $fell(bclk))
    else $error("bit clock high time wrong");
  a_bclk_low: assert property ($fell(bclk) |-> ##11 $rose(bclk))
    else $error("bit clock low time wrong");
  a_edge_quiet: assert property ($rose(bclk) |->
    $stable(lrclk) && $stable(serial_input_data)) else $error("link moved at bit clock rise");
  a_data_low_only: assert property ($changed(serial_input_data) |-> !bclk)
    else $error("data changed while bit clock high");
  a_lr_low_only: assert property ($changed(lrclk) |-> !bclk)
    else $error("channel clock changed while bit clock high");
  a_data_hold: assert property ($fell(bclk) |=> $stable(serial_input_data) [*8])
    else $error("data not held after bit clock fall");
  a_half_cycles: assert property (chg && seen |-> ncyc == 10'h2bf)
    else $error("channel half length wrong");
  a_half_bits: assert property (chg && seen |-> nbit == 6'h20)
    else $error("bit count per channel wrong");
endmodule // sdi_link_properties
`default_nettype wire

// ==== bench/spdif_tx_serial_input_port_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module spdif_tx_serial_input_port_tb_top;
  import sdi_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  sdi_fmt_e fmt = SDI_FMT_I2S;
  sdi_width_e width = SDI_W16;
  logic osr384 = 1'b0, osc = 1'b0, valid = 1'b1, ready = 1'b0, bq = 1'b0, lq = 1'b1;
  logic [23:0] left = 24'h800001, right = 24'h7ffffe, lw = 24'h000000;
  logic [31:0] hw = 32'h00000000;
  logic src_ready, rx_valid, biphase;
  logic [23:0] rx_left, rx_right;
  logic [47:0] q_rx[$], q_wire[$];
  bit hit_rx, hit_wire, stall_on, allow_skip;
  int n_mismatch = 0, n_compared = 0, skips = 0;
  sdi_link_if link ();
  sdi_src sdi_src_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .fmt_i(fmt), .width_i(width),
    .pair_valid_i(valid), .pair_ready_o(src_ready), .left_i(left), .right_i(right),
    .link(link.src));
  sdi_rx sdi_rx_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .link(link.dev), .fmt_i(fmt),
    .width_i(width), .osr384_i(osr384), .oversampling_clock_i(osc), .pair_valid_o(rx_valid),
    .pair_ready_i(ready), .left_o(rx_left), .right_o(rx_right), .biphase_clk_o(biphase));
  sdi_link_properties sdi_link_properties_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .bclk(link.bclk), .lrclk(link.lrclk), .serial_input_data(link.serial_input_data));
  always #2 mclk_i = ~mclk_i;
  // kept well below the synchroniser limit of the receiver
  always #20 osc = ~osc;
  function automatic logic [5:0] nbits();
    return (width == SDI_W16) ? SDI_W16_BITS : (width == SDI_W18) ? SDI_W18_BITS :
      (width == SDI_W20) ? SDI_W20_BITS : SDI_W24_BITS;
  endfunction
  function automatic logic [23:0] exw(logic [23:0] d);
    return d & ~(24'hffffff >> nbits());
  endfunction
  function automatic logic [23:0] ext(logic [31:0] h);
    logic [31:0] t;
    t = h << ((fmt == SDI_FMT_LJ) ? 6'h00 : (fmt == SDI_FMT_I2S) ? 6'h01 : 6'h20 - nbits());
    return exw(t[31:8]);
  endfunction
  task automatic chk(logic [47:0] got, logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // words seen before the first match belong to a half frame cut by reset
  task automatic take(ref logic [47:0] q[$], ref bit hit, input logic [47:0] got, input bit sk);
    int i;
    i = 0;
    while (i < q.size() && q[i] !== got)
      i++;
    if (i < q.size())
    begin
      if (hit && i > 0 && !sk)
        chk(got, q[0]);
      else
        n_compared++;
      if (hit)
        skips += i;
      hit = 1'b1;
      repeat (i + 1) void'(q.pop_front());
    end
    else if (hit)
      chk(got, (q.size() > 0) ? q[0] : ~got);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    if (src_ready === 1'b1)
    begin
      // a missing pair goes out as silence
      q_rx.push_back(valid ? {exw(left), exw(right)} : 48'h0);
      q_wire.push_back(valid ? {exw(left), exw(right)} : 48'h0);
      #1 left = 24'($urandom);
      right = 24'($urandom);
      valid = ($urandom % 8) != 0;
    end
  end
  always @(posedge mclk_i)
  begin
    if (rx_valid === 1'b1 && ready === 1'b1)
      take(q_rx, hit_rx, {rx_left, rx_right}, allow_skip);
    #1 ready = !stall_on && ($urandom % 4 != 0);
  end
  always @(posedge mclk_i)
  begin
    if (link.bclk === 1'b1 && bq === 1'b0)
    begin
      if (link.lrclk !== lq)
      begin
        if (lq === (fmt != SDI_FMT_I2S))
          lw = ext(hw);
        else
          take(q_wire, hit_wire, {lw, ext(hw)}, 1'b0);
        hw = 32'h00000000;
      end
      hw = {hw[30:0], link.serial_input_data};
      lq = link.lrclk;
    end
    bq = link.bclk;
  end
  task automatic run(input sdi_fmt_e f, input sdi_width_e w, input bit st);
    int t0;
    int hp;
    int ex;
    @(posedge mclk_i);
    #1 nrst_i = 1'b0;
    fmt = f;
    width = w;
    osr384 = ~osr384;
    allow_skip = st;
    hit_rx = 1'b0;
    hit_wire = 1'b0;
    skips = 0;
    q_rx.delete();
    q_wire.delete();
    left = 24'h800001;
    right = 24'h7ffffe;
    // first pair after reset is always real, so silence cannot pose as a match
    valid = 1'b1;
    repeat (20) @(posedge mclk_i);
    #1 nrst_i = 1'b1;
    repeat (st ? 3840 : 5120) @(posedge mclk_i);
    if (st)
    begin
      stall_on = 1'b1;
      repeat (6400) @(posedge mclk_i);
      stall_on = 1'b0;
      repeat (3840) @(posedge mclk_i);
      chk({47'h0, skips != 0}, 48'h1);
    end
    chk({46'h0, hit_rx, hit_wire}, 48'h3);
    ex = osr384 ? 120 : 80;
    @(biphase);
    t0 = int'($time);
    @(biphase);
    hp = int'($time) - t0;
    if (hp > ex - 5 && hp < ex + 5)
      hp = ex;
    chk(48'(hp), 48'(ex));
  endtask
  initial
  begin
    void'($urandom(32'h8d11d1c9));
    for (int f = 0; f < 3; f++)
      for (int w = 0; w < 4; w++)
        run(sdi_fmt_e'(f), sdi_width_e'(w), f == 2 && w == 3);
    print_verdict();
  end
  initial
  begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
endmodule // spdif_tx_serial_input_port_tb_top
`default_nettype wire
